// ==== hold_reg_pkg.sv ====
// Summary of operation
// - Register values are scaled binary integers, engineering value times ten or hundred.
// - Written frequency values are divided by their scale factor for internal use; process values pass undivided.
// - Each register LSB equals its listed resolution; may be a fractional step.
// - Values wider than a register span two consecutive addresses.
// - Frequency command 0..4000, used only when source select picks network.
// - Process value 0..1000, used only when its source select picks network.
// - Monitors are read-only; command and process registers are read-write.
// - Output frequency monitor reports live frequency 0..4000.
// - Current monitor is filtered with 100 ms constant, 0..2000.
// - PID feedback is process value times scale factor, two words, 0..999900.
// - Input terminal states: five terminals on bits 0 to 4.
// - Output terminal states: first output bit 0, alarm relay bit 2.
// - Scaled frequency is frequency times scale constant, two words, 0..3996000.
// - Output voltage monitor reports 0..20000.
// - Run hours count whole hours in run mode, two words, 0..999999.
// - Trip counter counts trip events 0..65535.
// - Heatsink temperature reports 0..2000.
// - DC bus voltage reports 0..9999.
// - Thermal accumulation reports 0..1000.
package hold_reg_pkg;

  localparam logic [15:0] ADDR_FREQ_CMD    = 16'h0002;
  localparam logic [15:0] ADDR_DRIVE_STATE = 16'h0003;
  localparam logic [15:0] ADDR_PV_IN       = 16'h0005;
  localparam logic [15:0] ADDR_TRIP_CNT    = 16'h0011;
  localparam logic [15:0] ADDR_FREQ_NOW    = 16'h1002;
  localparam logic [15:0] ADDR_CURR_NOW    = 16'h1003;
  localparam logic [15:0] ADDR_ROT_DIR     = 16'h1004;
  localparam logic [15:0] ADDR_PID_HI      = 16'h1005;
  localparam logic [15:0] ADDR_PID_LO      = 16'h1006;
  localparam logic [15:0] ADDR_IN_TERM     = 16'h1007;
  localparam logic [15:0] ADDR_OUT_TERM    = 16'h1008;
  localparam logic [15:0] ADDR_SFREQ_HI    = 16'h1009;
  localparam logic [15:0] ADDR_SFREQ_LO    = 16'h100A;
  localparam logic [15:0] ADDR_VOLT_NOW    = 16'h100C;
  localparam logic [15:0] ADDR_RUN_HI      = 16'h100E;
  localparam logic [15:0] ADDR_RUN_LO      = 16'h100F;
  localparam logic [15:0] ADDR_PON_HI      = 16'h1010;
  localparam logic [15:0] ADDR_PON_LO      = 16'h1011;
  localparam logic [15:0] ADDR_HEATSINK    = 16'h116A;
  localparam logic [15:0] ADDR_DC_BUS      = 16'h116C;
  localparam logic [15:0] ADDR_THERMAL     = 16'h116D;

  localparam logic [15:0] FREQ_MAX    = 16'h0FA0;
  localparam logic [15:0] PV_MAX      = 16'h03E8;
  localparam logic [15:0] CURR_MAX    = 16'h07D0;
  localparam logic [15:0] VOLT_MAX    = 16'h4E20;
  localparam logic [15:0] TEMP_MAX    = 16'h07D0;
  localparam logic [15:0] DCBUS_MAX   = 16'h270F;
  localparam logic [15:0] THERM_MAX   = 16'h03E8;
  localparam logic [15:0] TRIP_MAX    = 16'hFFFF;
  localparam logic [31:0] PID_MAX     = 32'h000F_41DC;
  localparam logic [31:0] SFREQ_MAX   = 32'h003C_F960;
  localparam logic [31:0] HOURS_MAX   = 32'h000F_423F;
  localparam logic [15:0] RESET_WORD  = 16'h0000;

  localparam logic [7:0] FREQ_SRC_NETWORK = 8'h03;
  localparam logic [7:0] PV_SRC_NETWORK   = 8'h02;

  // Scale factor from network integer to internal whole units.
  localparam logic [7:0] FREQ_SCALE = 8'h0A;
  localparam logic [7:0] PV_SCALE   = 8'h0A;

  localparam int CLK_HZ        = 100_000_000;
  localparam int FILTER_TAU_MS = 100;
  localparam int FILTER_TICKS  = CLK_HZ / 1000 * FILTER_TAU_MS;
  localparam int SEC_PER_HOUR  = 3600;

  localparam int IN_TERM_BIT0  = 0;
  localparam int OUT_TERM_BIT  = 0;
  localparam int ALARM_BIT     = 2;

  typedef enum logic [3:0]
  {
    ST_INITIAL   = 4'h0,
    ST_STOP      = 4'h2,
    ST_RUN       = 4'h3,
    ST_COAST     = 4'h4,
    ST_JOG       = 4'h5,
    ST_DC_BRAKE  = 4'h6,
    ST_RETRY     = 4'h7,
    ST_TRIP      = 4'h8,
    ST_UNDERVOLT = 4'h9
  } drive_state_t;

  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic        valid;
    logic        error;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef struct packed
  {
    logic [15:0] freq;
    logic [15:0] current;
    logic [1:0]  direction;
    logic [15:0] voltage;
    logic [15:0] heatsink;
    logic [15:0] dc_bus;
    logic [15:0] thermal;
    logic [4:0]  in_terms;
    logic        out_term;
    logic        alarm_relay;
    logic [3:0]  state;
    logic        trip_event;
    logic        running;
    logic        second_tick;
  } drive_mon_t;

endpackage

// ==== hold_reg_bank.sv ====
`timescale 1ns/1ps
module drive_network_holding_registers
  import hold_reg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire reg_req_t    req,
  input  wire drive_mon_t  mon,
  input  wire logic [7:0]  frequency_source_select,
  input  wire logic [7:0]  process_value_source_select,
  input  wire logic [15:0] process_scale_factor,
  input  wire logic [15:0] frequency_scale_constant,
  input  wire logic [15:0] local_freq_cmd,
  input  wire logic [15:0] sensor_process_value,
  output reg_rsp_t         rsp,
  output logic [15:0]      freq_target_hz,
  output logic [15:0]      process_variable,
  output logic [15:0]      freq_target_raw
);

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  logic [15:0] freq_cmd_r;
  logic [15:0] pv_in_r;
  logic        wr_freq;
  logic        wr_pv;

  assign wr_freq = req.valid && req.write && req.addr == ADDR_FREQ_CMD;
  assign wr_pv   = req.valid && req.write && req.addr == ADDR_PV_IN;

  // Values outside the listed range are refused and the old value is kept.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      freq_cmd_r <= RESET_WORD;
    else if (wr_freq && req.wdata <= FREQ_MAX)
      freq_cmd_r <= req.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pv_in_r <= RESET_WORD;
    else if (wr_pv && req.wdata <= PV_MAX)
      pv_in_r <= req.wdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source selection and descaling of network values.
  logic [15:0] freq_sel;
  logic [15:0] pv_sel;

  assign freq_sel = (frequency_source_select == FREQ_SRC_NETWORK) ?
                    freq_cmd_r : local_freq_cmd;
  assign pv_sel = (process_value_source_select == PV_SRC_NETWORK) ?
                  pv_in_r : sensor_process_value;

  // Division by a constant folds into a small multiplier; whole units only.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      freq_target_raw  <= RESET_WORD;
      freq_target_hz   <= RESET_WORD;
      process_variable <= RESET_WORD;
    end
    else
    begin
      freq_target_raw  <= freq_sel;
      freq_target_hz   <= freq_sel / {8'h00, FREQ_SCALE};
      process_variable <= pv_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Current filter: first-order low pass, updated once per millisecond.
  localparam int MS_TICKS = CLK_HZ / 1000;
  logic [16:0] ms_cnt_r;
  logic        ms_tick;
  logic [23:0] curr_acc_r;
  logic [15:0] curr_in;
  logic [23:0] curr_acc_nxt;

  assign ms_tick = ms_cnt_r == 17'(MS_TICKS - 1);
  assign curr_in = (mon.current > CURR_MAX) ? CURR_MAX : mon.current;

  always_ff @(posedge clk)
  begin
    if (sys_rst || ms_tick)
      ms_cnt_r <= 17'h0_0000;
    else
      ms_cnt_r <= ms_cnt_r + 17'h0_0001;
  end

  // Accumulator holds 128 times the output; step 1/128 approximates 1 ms/100 ms.
  assign curr_acc_nxt = curr_acc_r + {8'h00, curr_in}
                        - {7'h00, curr_acc_r[23:7]};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      curr_acc_r <= 24'h00_0000;
    else if (ms_tick)
      curr_acc_r <= curr_acc_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Products spanning two registers.
  logic [31:0] pid_prod;
  logic [31:0] sfreq_prod;
  logic [31:0] pid_r;
  logic [31:0] sfreq_r;

  assign pid_prod   = {16'h0000, pv_sel} * {16'h0000, process_scale_factor};
  assign sfreq_prod = {16'h0000, mon.freq}
                      * {16'h0000, frequency_scale_constant};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pid_r   <= 32'h0000_0000;
      sfreq_r <= 32'h0000_0000;
    end
    else
    begin
      pid_r   <= (pid_prod > PID_MAX) ? PID_MAX : pid_prod;
      sfreq_r <= (sfreq_prod > SFREQ_MAX) ? SFREQ_MAX : sfreq_prod;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hour counters and trip counter.
  logic [11:0] run_sec_r;
  logic [11:0] pon_sec_r;
  logic [31:0] run_hours_r;
  logic [31:0] pon_hours_r;
  logic [15:0] trip_cnt_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      run_sec_r   <= 12'h000;
      run_hours_r <= 32'h0000_0000;
    end
    else if (mon.second_tick && mon.running)
    begin
      if (run_sec_r == 12'(SEC_PER_HOUR - 1))
      begin
        run_sec_r <= 12'h000;
        if (run_hours_r < HOURS_MAX)
          run_hours_r <= run_hours_r + 32'h0000_0001;
      end
      else
        run_sec_r <= run_sec_r + 12'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pon_sec_r   <= 12'h000;
      pon_hours_r <= 32'h0000_0000;
    end
    else if (mon.second_tick)
    begin
      if (pon_sec_r == 12'(SEC_PER_HOUR - 1))
      begin
        pon_sec_r <= 12'h000;
        if (pon_hours_r < HOURS_MAX)
          pon_hours_r <= pon_hours_r + 32'h0000_0001;
      end
      else
        pon_sec_r <= pon_sec_r + 12'h001;
    end
  end

  // Saturates rather than wrapping so a flood of trips stays visible.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      trip_cnt_r <= RESET_WORD;
    else if (mon.trip_event && trip_cnt_r != TRIP_MAX)
      trip_cnt_r <= trip_cnt_r + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux and response.
  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] m);
    clip = (v > m) ? m : v;
  endfunction

  logic [15:0] rd_data;
  logic        rd_hit;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = RESET_WORD;
    case (req.addr)
      ADDR_FREQ_CMD:    rd_data = freq_cmd_r;
      ADDR_DRIVE_STATE: rd_data = {12'h000, mon.state};
      ADDR_PV_IN:       rd_data = pv_in_r;
      ADDR_TRIP_CNT:    rd_data = trip_cnt_r;
      ADDR_FREQ_NOW:    rd_data = clip(mon.freq, FREQ_MAX);
      ADDR_CURR_NOW:    rd_data = clip(curr_acc_r[22:7], CURR_MAX);
      ADDR_ROT_DIR:     rd_data = {14'h0000, mon.direction};
      ADDR_PID_HI:      rd_data = pid_r[31:16];
      ADDR_PID_LO:      rd_data = pid_r[15:0];
      ADDR_IN_TERM:     rd_data = {11'h000, mon.in_terms};
      ADDR_OUT_TERM:    rd_data = {13'h0000, mon.alarm_relay, 1'b0,
                                   mon.out_term};
      ADDR_SFREQ_HI:    rd_data = sfreq_r[31:16];
      ADDR_SFREQ_LO:    rd_data = sfreq_r[15:0];
      ADDR_VOLT_NOW:    rd_data = clip(mon.voltage, VOLT_MAX);
      ADDR_RUN_HI:      rd_data = run_hours_r[31:16];
      ADDR_RUN_LO:      rd_data = run_hours_r[15:0];
      ADDR_PON_HI:      rd_data = pon_hours_r[31:16];
      ADDR_PON_LO:      rd_data = pon_hours_r[15:0];
      ADDR_HEATSINK:    rd_data = clip(mon.heatsink, TEMP_MAX);
      ADDR_DC_BUS:      rd_data = clip(mon.dc_bus, DCBUS_MAX);
      ADDR_THERMAL:     rd_data = clip(mon.thermal, THERM_MAX);
      default:          rd_hit  = 1'b0;
    endcase
  end

  logic wr_ok;
  assign wr_ok = (wr_freq && req.wdata <= FREQ_MAX) ||
                 (wr_pv && req.wdata <= PV_MAX);

  // A write to any monitor or unmapped address answers with error.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rsp <= '0;
    else
    begin
      rsp.valid <= req.valid;
      rsp.error <= req.valid && (req.write ? !wr_ok : !rd_hit);
      rsp.rdata <= (req.valid && !req.write) ? rd_data : RESET_WORD;
    end
  end

endmodule

// ==== hold_reg_bank_properties.sv ====
`timescale 1ns/1ps
module drive_holding_checker
  import hold_reg_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire reg_req_t    req,
  input wire drive_mon_t  mon,
  input wire logic [7:0]  frequency_source_select,
  input wire logic [7:0]  process_value_source_select,
  input wire logic [15:0] local_freq_cmd,
  input wire logic [15:0] sensor_process_value,
  input wire reg_rsp_t    rsp,
  input wire logic [15:0] freq_target_hz,
  input wire logic [15:0] process_variable,
  input wire logic [15:0] freq_target_raw
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rd_q;
  logic wr_q;
  logic net_f;
  assign rd_q = req.valid && !req.write;
  assign wr_q = req.valid && req.write;
  assign net_f = frequency_source_select == FREQ_SRC_NETWORK;
  //////////////////////////////////////////////////////////////////////////////
  property p_quiet; !req.valid |=> !rsp.valid; endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without request");
  property p_ro; wr_q && req.addr != ADDR_FREQ_CMD && req.addr != ADDR_PV_IN
    |=> rsp.valid && rsp.error; endproperty
  a_ro: assert property (p_ro)
    else $error("write to read-only place accepted");
  property p_frange; wr_q && req.addr == ADDR_FREQ_CMD && req.wdata > FREQ_MAX
    |=> rsp.error; endproperty
  a_frange: assert property (p_frange)
    else $error("frequency above range accepted");
  property p_prange; wr_q && req.addr == ADDR_PV_IN && req.wdata > PV_MAX
    |=> rsp.error; endproperty
  a_prange: assert property (p_prange)
    else $error("process value above range accepted");
  property p_fnet; wr_q && req.addr == ADDR_FREQ_CMD && req.wdata <= FREQ_MAX
    && net_f ##1 net_f |=> freq_target_raw == $past(req.wdata, 2); endproperty
  a_fnet: assert property (p_fnet)
    else $error("network frequency not applied");
  property p_flocal; !net_f |=> freq_target_raw == $past(local_freq_cmd);
  endproperty
  a_flocal: assert property (p_flocal)
    else $error("local frequency not applied");
  property p_hz; freq_target_hz == freq_target_raw / 16'h000A; endproperty
  a_hz: assert property (p_hz)
    else $error("frequency not divided by ten");
  property p_plocal; process_value_source_select != PV_SRC_NETWORK
    |=> process_variable == $past(sensor_process_value); endproperty
  a_plocal: assert property (p_plocal)
    else $error("sensor process value not applied");
  property p_dir; rd_q && req.addr == ADDR_ROT_DIR
    |=> rsp.rdata == {14'h0000, $past(mon.direction)}; endproperty
  a_dir: assert property (p_dir)
    else $error("direction read wrong");
  property p_term; rd_q && req.addr == ADDR_IN_TERM
    |=> rsp.rdata == {11'h000, $past(mon.in_terms)}; endproperty
  a_term: assert property (p_term)
    else $error("input terminal read wrong");
endmodule
bind drive_network_holding_registers drive_holding_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .req(req), .mon(mon),
  .frequency_source_select(frequency_source_select),
  .process_value_source_select(process_value_source_select),
  .local_freq_cmd(local_freq_cmd),
  .sensor_process_value(sensor_process_value), .rsp(rsp),
  .freq_target_hz(freq_target_hz), .process_variable(process_variable),
  .freq_target_raw(freq_target_raw));

// ==== network_host_model.sv ====
`timescale 1ns/1ps
module network_host_model
  import hold_reg_pkg::*;
(
  input  wire logic     clk,
  input  wire reg_rsp_t rsp,
  output reg_req_t      req
);
  initial req = '0;
  // The host scales its values into range itself; an out-of-range word
  // goes out only when a test wants to see it refused.
  task automatic access(input logic w, input logic [15:0] a, d,
                        output logic [15:0] rd, output logic er);
    @(negedge clk);
    req = '{1'b1, w, a, d};
    @(negedge clk);
    rd = rsp.rdata;
    er = rsp.valid ? rsp.error : 1'bx;
    // Released lines show the inverse so stale values never match.
    req = '{1'b0, w, ~a, ~d};
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import hold_reg_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  drive_mon_t  mon = '0;
  logic [7:0]  freq_sel = FREQ_SRC_NETWORK;
  logic [7:0]  pv_sel = PV_SRC_NETWORK;
  reg_req_t    req;
  reg_rsp_t    rsp;
  logic [15:0] freq_hz;
  logic [15:0] pv_out;
  logic [15:0] freq_raw;
  int          num_errors = 0;
  int          comparisons = 0;
  int          i;
  localparam logic [15:0] MON_ADDR [8] = '{ADDR_FREQ_NOW, ADDR_IN_TERM,
    ADDR_SFREQ_HI, ADDR_SFREQ_LO, ADDR_VOLT_NOW, ADDR_HEATSINK, ADDR_DC_BUS,
    ADDR_THERMAL};
  localparam logic [15:0] MON_EXP [8] = '{FREQ_MAX, 16'h0015, 16'h003C,
    16'hF960, VOLT_MAX, TEMP_MAX, DCBUS_MAX, THERM_MAX};
  always #5 clk = ~clk;
  drive_network_holding_registers u_drive_network_holding_registers (
    .clk(clk), .sys_rst(sys_rst), .req(req), .mon(mon),
    .frequency_source_select(freq_sel), .process_value_source_select(pv_sel),
    .process_scale_factor(16'h0003), .frequency_scale_constant(16'h03E7),
    .local_freq_cmd(16'h0123), .sensor_process_value(16'h0200), .rsp(rsp),
    .freq_target_hz(freq_hz), .process_variable(pv_out),
    .freq_target_raw(freq_raw));
  network_host_model u_network_host_model (.clk(clk), .rsp(rsp), .req(req));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t error flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d, input logic e,
                     input logic [15:0] x);
    logic [15:0] rd;
    logic        er;
    u_network_host_model.access(w, a, d, rd, er);
    check_flag(er, e);
    check_word(rd, x);
  endtask
  task automatic pulse(input logic trip);
    if (trip) mon.trip_event = 1'b1;
    else mon.second_tick = 1'b1;
    ticks(1);
    mon.trip_event = 1'b0;
    mon.second_tick = 1'b0;
    ticks(1);
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    ticks(6);
    sys_rst = 1'b0;
    acc(1'b1, ADDR_FREQ_CMD, FREQ_MAX, 1'b0, RESET_WORD);
    acc(1'b1, ADDR_FREQ_CMD, FREQ_MAX + 16'h0001, 1'b1, RESET_WORD);
    acc(1'b0, ADDR_FREQ_CMD, RESET_WORD, 1'b0, FREQ_MAX);
    check_word(freq_raw, FREQ_MAX);
    check_word(freq_hz, 16'h0190);
    freq_sel = 8'h00;
    ticks(2);
    check_word(freq_raw, 16'h0123);
    $display("test frequency command done");
    acc(1'b1, ADDR_PV_IN, PV_MAX, 1'b0, RESET_WORD);
    acc(1'b1, ADDR_PV_IN, PV_MAX + 16'h0001, 1'b1, RESET_WORD);
    acc(1'b0, ADDR_PV_IN, RESET_WORD, 1'b0, PV_MAX);
    check_word(pv_out, PV_MAX);
    acc(1'b0, ADDR_PID_HI, RESET_WORD, 1'b0, RESET_WORD);
    acc(1'b0, ADDR_PID_LO, RESET_WORD, 1'b0, 16'h0BB8);
    pv_sel = 8'h00;
    ticks(2);
    check_word(pv_out, 16'h0200);
    acc(1'b1, ADDR_FREQ_NOW, 16'h0001, 1'b1, RESET_WORD);
    acc(1'b1, ADDR_TRIP_CNT, 16'h0001, 1'b1, RESET_WORD);
    acc(1'b0, 16'h0004, RESET_WORD, 1'b1, RESET_WORD);
    $display("test process value and access done");
    mon = '{FREQ_MAX, 16'h0000, 2'h0, VOLT_MAX, TEMP_MAX, DCBUS_MAX,
            THERM_MAX, 5'h15, 1'b1, 1'b1, 4'h0, 1'b0, 1'b1, 1'b0};
    for (i = 0; i < 10; i++)
    begin
      if (i == 1) continue;
      mon.state = i[3:0];
      mon.direction = 2'(i % 3);
      ticks(2);
      acc(1'b0, ADDR_DRIVE_STATE, RESET_WORD, 1'b0, 16'(i));
      acc(1'b0, ADDR_ROT_DIR, RESET_WORD, 1'b0, 16'(i % 3));
    end
    for (i = 0; i < 8; i++)
      acc(1'b0, MON_ADDR[i], RESET_WORD, 1'b0, MON_EXP[i]);
    acc(1'b0, ADDR_OUT_TERM, RESET_WORD, 1'b0, 16'h0005);
    acc(1'b0, ADDR_CURR_NOW, RESET_WORD, 1'b0, RESET_WORD);
    $display("test monitors done");
    repeat (3) pulse(1'b1);
    acc(1'b0, ADDR_TRIP_CNT, RESET_WORD, 1'b0, 16'h0003);
    repeat (3599) pulse(1'b0);
    acc(1'b0, ADDR_RUN_LO, RESET_WORD, 1'b0, RESET_WORD);
    pulse(1'b0);
    acc(1'b0, ADDR_RUN_HI, RESET_WORD, 1'b0, RESET_WORD);
    acc(1'b0, ADDR_RUN_LO, RESET_WORD, 1'b0, 16'h0001);
    acc(1'b0, ADDR_PON_LO, RESET_WORD, 1'b0, 16'h0001);
    $display("test event counters done");
    print_verdict();
  end
endmodule
